/* inc/stiu_pkg.sv */
// Package for the sensor threshold interrupt unit: register map, field
// positions and reset values. Assumes byte-wide registers on one clock.
package stiu_pkg;
    localparam logic [7:0] ADDR_BIO_RES_HI = 8'h87;
    localparam logic [7:0] ADDR_BIO_RES_LO = 8'h88;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h89;
    localparam logic [7:0] ADDR_LOW_LIM_HI = 8'h8A;
    localparam logic [7:0] ADDR_LOW_LIM_LO = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_LIM_HI = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_LIM_LO = 8'h8D;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h8E;
    // Control register fields.
    localparam int CTRL_SRC_SEL = 0;
    localparam int CTRL_LIM_EN = 1;
    localparam int CTRL_ALS_RDY_EN = 2;
    localparam int CTRL_BIO_RDY_EN = 3;
    localparam int CTRL_CNT_LSB = 4;
    localparam int CNT_CODE_W = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'h7F;
    // Status register fields.
    localparam int STAT_HIGH = 0;
    localparam int STAT_LOW = 1;
    localparam int STAT_ALS_RDY = 2;
    localparam int STAT_BIO_RDY = 3;
    localparam int STAT_W = 4;
    localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
    // Consecutive run counter, wide enough for the largest count of 128.
    localparam int RUN_W = 8;
    localparam logic [RUN_W-1:0] RUN_ONE = 8'h01;
    localparam logic [RUN_W-1:0] RUN_ZERO = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [7:0] READ_ZERO = 8'h00;
    typedef enum logic [2:0] {
        RUN_NONE = 3'b001,
        RUN_LOW = 3'b010,
        RUN_HIGH = 3'b100
    } stiu_run_e;
endpackage : stiu_pkg

/* rtl/stiu_limit_qual.sv */
// Limit qualifier: compares samples with the limits and counts runs.
// Assumes samples and limits come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module stiu_limit_qual (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic sampleValid,
    input wire logic [15:0] sample,
    input wire logic [15:0] lowLimit,
    input wire logic [15:0] highLimit,
    input wire logic [2:0] countCode,
    output logic hitHigh,
    output logic hitLow
);
    stiu_pkg::stiu_run_e runState;
    stiu_pkg::stiu_run_e next_runState;
    logic [stiu_pkg::RUN_W-1:0] runCount;
    logic [stiu_pkg::RUN_W-1:0] next_runCount;
    logic [stiu_pkg::RUN_W-1:0] required;
    logic above;
    logic below;
    logic next_hitHigh;
    logic next_hitLow;

    default clocking cbQual @(posedge sys_clk);
    endclocking

    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    // A result above the high limit wins if the limits are set inverted.
    assign above = sample > highLimit;
    assign below = (sample < lowLimit) && !above;
    assign required = stiu_pkg::RUN_ONE << countCode;

    always_comb
    begin
        next_runState = runState;
        next_runCount = runCount;
        next_hitHigh = 1'b0;
        next_hitLow = 1'b0;
        if (sampleValid)
        begin
            if (above)
            begin
                next_runState = stiu_pkg::RUN_HIGH;
                next_runCount = (runState == stiu_pkg::RUN_HIGH) ?
                    runCount + stiu_pkg::RUN_ONE : stiu_pkg::RUN_ONE;
            end
            else if (below)
            begin
                next_runState = stiu_pkg::RUN_LOW;
                next_runCount = (runState == stiu_pkg::RUN_LOW) ?
                    runCount + stiu_pkg::RUN_ONE : stiu_pkg::RUN_ONE;
            end
            else
            begin
                next_runState = stiu_pkg::RUN_NONE;
                next_runCount = stiu_pkg::RUN_ZERO;
            end
            if ((above || below) && next_runCount >= required)
            begin
                next_hitHigh = above;
                next_hitLow = below;
                next_runCount = stiu_pkg::RUN_ZERO;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            runState <= stiu_pkg::RUN_NONE;
            runCount <= stiu_pkg::RUN_ZERO;
            hitHigh <= 1'b0;
            hitLow <= 1'b0;
        end
        else
        begin
            runState <= next_runState;
            runCount <= next_runCount;
            hitHigh <= next_hitHigh;
            hitLow <= next_hitLow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence sAboveSample;
        sampleValid && (sample > highLimit);
    endsequence

    sequence sInRange;
        sampleValid && !(sample > highLimit) && !(sample < lowLimit);
    endsequence

    AST_SINGLE_HIT: assert property (
        (sAboveSample and (countCode == 3'h0)) |=> hitHigh)
        else $error("Code zero did not raise a high hit at once.");
    AST_IN_RANGE_RESTART: assert property (
        sInRange |=> (runCount == stiu_pkg::RUN_ZERO) && !hitHigh && !hitLow)
        else $error("In-range sample did not restart the run.");
    AST_NO_EARLY_HIT: assert property (
        (sAboveSample and (countCode == 3'h1) and (runState != stiu_pkg::RUN_HIGH))
        |=> !hitHigh)
        else $error("High hit raised before two consecutive samples.");
endmodule : stiu_limit_qual
`default_nettype wire

/* rtl/stiu_top.sv */
// Sensor threshold interrupt unit: result, limit, control and status
// registers behind a byte register port, and the active-low interrupt.
// Assumes the register port and measurement strobes share sys_clk.
//
// Function
// - Biosensor result is two read-only bytes; writes never change it.
// - Lower address holds result bits 15:8, higher address bits 7:0.
// - Count code n requires two to the n samples; code resets to zero.
// - Data-ready interrupts per source only while its enable bit is set.
// - Limit interrupts only while the limit enable bit is set.
// - Select 0 compares biosensor results, select 1 ambient results.
// - Low limit is sixteen bits in two writable byte registers.
// - High limit is sixteen bits in two writable byte registers.
// - Each limit keeps bits 15:8 at the lower address, 7:0 higher.
// - Status register holds bio ready, ambient ready, low and high flags.
// - A flag sets on its event and stays until written with one.
// - Interrupt pin is low while any status flag is set.
`timescale 1ns/100ps
`default_nettype none
module stiu_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic bioValid,
    input wire logic [15:0] bioData,
    input wire logic alsValid,
    input wire logic [15:0] alsData,
    output logic intN
);
    logic [15:0] bioResult;
    logic [7:0] irqControl;
    logic [15:0] lowLimit;
    logic [15:0] highLimit;
    logic [stiu_pkg::STAT_W-1:0] irqStatus;
    logic [stiu_pkg::STAT_W-1:0] next_irqStatus;
    logic [stiu_pkg::STAT_W-1:0] statSet;
    logic [stiu_pkg::STAT_W-1:0] statClr;
    logic [7:0] next_regRdata;
    logic limValid;
    logic [15:0] limSample;
    logic hitHigh;
    logic hitLow;
    logic bio_ready_irq_enable;
    logic als_ready_irq_enable;
    logic limit_irq_enable;
    logic limit_source_select;

    default clocking cbTop @(posedge sys_clk);
    endclocking

    default disable iff (!nrst);

    function automatic logic wrAt(input logic [7:0] addr);
        wrAt = regWrite && (regAddr == addr);
    endfunction : wrAt

    ////////////////////////////////////////////////////////////////////////
    assign bio_ready_irq_enable = irqControl[stiu_pkg::CTRL_BIO_RDY_EN];
    assign als_ready_irq_enable = irqControl[stiu_pkg::CTRL_ALS_RDY_EN];
    assign limit_irq_enable = irqControl[stiu_pkg::CTRL_LIM_EN];
    assign limit_source_select = irqControl[stiu_pkg::CTRL_SRC_SEL];

    // The result only follows the measurement, so host writes are dropped.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            bioResult <= stiu_pkg::RESULT_RESET;
        else if (bioValid)
            bioResult <= bioData;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            irqControl <= stiu_pkg::CTRL_RESET;
        else if (wrAt(stiu_pkg::ADDR_IRQ_CTRL))
            irqControl <= regWdata & stiu_pkg::CTRL_MASK;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lowLimit <= stiu_pkg::LIMIT_RESET;
            highLimit <= stiu_pkg::LIMIT_RESET;
        end
        else
        begin
            if (wrAt(stiu_pkg::ADDR_LOW_LIM_HI))
                lowLimit[15:8] <= regWdata;
            if (wrAt(stiu_pkg::ADDR_LOW_LIM_LO))
                lowLimit[7:0] <= regWdata;
            if (wrAt(stiu_pkg::ADDR_HIGH_LIM_HI))
                highLimit[15:8] <= regWdata;
            if (wrAt(stiu_pkg::ADDR_HIGH_LIM_LO))
                highLimit[7:0] <= regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign limValid = limit_source_select ? alsValid : bioValid;
    assign limSample = limit_source_select ? alsData : bioData;

    stiu_limit_qual u_qual (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sampleValid(limValid),
        .sample(limSample),
        .lowLimit(lowLimit),
        .highLimit(highLimit),
        .countCode(irqControl[stiu_pkg::CTRL_CNT_LSB +: stiu_pkg::CNT_CODE_W]),
        .hitHigh(hitHigh),
        .hitLow(hitLow)
    );

    ////////////////////////////////////////////////////////////////////////
    // A new event in the clearing cycle wins so no event is lost.
    always_comb
    begin
        statSet = stiu_pkg::STAT_RESET;
        statSet[stiu_pkg::STAT_BIO_RDY] = bioValid && bio_ready_irq_enable;
        statSet[stiu_pkg::STAT_ALS_RDY] = alsValid && als_ready_irq_enable;
        statSet[stiu_pkg::STAT_HIGH] = hitHigh && limit_irq_enable;
        statSet[stiu_pkg::STAT_LOW] = hitLow && limit_irq_enable;
        statClr = wrAt(stiu_pkg::ADDR_IRQ_STATUS) ?
            regWdata[stiu_pkg::STAT_W-1:0] : stiu_pkg::STAT_RESET;
        next_irqStatus = (irqStatus & ~statClr) | statSet;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irqStatus <= stiu_pkg::STAT_RESET;
            intN <= 1'b1;
        end
        else
        begin
            irqStatus <= next_irqStatus;
            intN <= ~|next_irqStatus;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data is captured on the read strobe and shown the next cycle.
    always_comb
    begin
        if (regAddr == stiu_pkg::ADDR_BIO_RES_HI)
            next_regRdata = bioResult[15:8];
        else if (regAddr == stiu_pkg::ADDR_BIO_RES_LO)
            next_regRdata = bioResult[7:0];
        else if (regAddr == stiu_pkg::ADDR_IRQ_CTRL)
            next_regRdata = irqControl;
        else if (regAddr == stiu_pkg::ADDR_LOW_LIM_HI)
            next_regRdata = lowLimit[15:8];
        else if (regAddr == stiu_pkg::ADDR_LOW_LIM_LO)
            next_regRdata = lowLimit[7:0];
        else if (regAddr == stiu_pkg::ADDR_HIGH_LIM_HI)
            next_regRdata = highLimit[15:8];
        else if (regAddr == stiu_pkg::ADDR_HIGH_LIM_LO)
            next_regRdata = highLimit[7:0];
        else if (regAddr == stiu_pkg::ADDR_IRQ_STATUS)
            next_regRdata = {4'h0, irqStatus};
        else
            next_regRdata = stiu_pkg::READ_ZERO;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            regRdata <= stiu_pkg::READ_ZERO;
        else if (regRead)
            regRdata <= next_regRdata;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence sResultWrite;
        regWrite && !bioValid &&
            ((regAddr == stiu_pkg::ADDR_BIO_RES_HI) ||
             (regAddr == stiu_pkg::ADDR_BIO_RES_LO));
    endsequence

    sequence sBioClear;
        wrAt(stiu_pkg::ADDR_IRQ_STATUS) && regWdata[stiu_pkg::STAT_BIO_RDY] &&
            !bioValid;
    endsequence

    AST_RESULT_READONLY: assert property (
        sResultWrite |=> $stable(bioResult))
        else $error("Host write altered the biosensor result.");

    AST_RESULT_CAPTURE: assert property (
        bioValid |=> bioResult == $past(bioData))
        else $error("Biosensor result did not capture the sample.");

    AST_RESULT_HIGH_BYTE: assert property (
        (regRead && regAddr == stiu_pkg::ADDR_BIO_RES_HI)
        |=> regRdata == $past(bioResult[15:8]))
        else $error("High result byte does not read bits 15 to 8.");

    AST_RESULT_LOW_BYTE: assert property (
        (regRead && regAddr == stiu_pkg::ADDR_BIO_RES_LO)
        |=> regRdata == $past(bioResult[7:0]))
        else $error("Low result byte does not read bits 7 to 0.");

    AST_CTRL_WRITE: assert property (
        wrAt(stiu_pkg::ADDR_IRQ_CTRL)
        |=> irqControl == ($past(regWdata) & stiu_pkg::CTRL_MASK))
        else $error("Control write not stored.");

    AST_BIO_READY_GATE: assert property (
        bioValid |=> irqStatus[stiu_pkg::STAT_BIO_RDY] ==
            ($past(bio_ready_irq_enable) ||
             $past(irqStatus[stiu_pkg::STAT_BIO_RDY]) &&
             !$past(statClr[stiu_pkg::STAT_BIO_RDY])))
        else $error("Bio ready flag ignores its enable.");

    AST_ALS_READY_GATE: assert property (
        (!als_ready_irq_enable && !irqStatus[stiu_pkg::STAT_ALS_RDY])
        |=> !irqStatus[stiu_pkg::STAT_ALS_RDY])
        else $error("Ambient ready flag set while disabled.");

    AST_LIMIT_GATE: assert property (
        (!limit_irq_enable && !irqStatus[stiu_pkg::STAT_HIGH]) |=>
            !irqStatus[stiu_pkg::STAT_HIGH])
        else $error("High flag set while limit interrupts disabled.");

    AST_LIMIT_GATE_LOW: assert property (
        (!limit_irq_enable && !irqStatus[stiu_pkg::STAT_LOW]) |=>
            !irqStatus[stiu_pkg::STAT_LOW])
        else $error("Low flag set while limit interrupts disabled.");

    AST_SOURCE_SELECT: assert property (
        limValid == (limit_source_select ? alsValid : bioValid) &&
            (!limit_source_select -> limSample == bioData))
        else $error("Limit source does not follow the select bit.");

    AST_SOURCE_ALS: assert property (
        limit_source_select |-> limSample == alsData)
        else $error("Ambient source not compared when selected.");

    AST_LOW_LIMIT_WRITE: assert property (
        wrAt(stiu_pkg::ADDR_LOW_LIM_HI) |=> lowLimit[15:8] == $past(regWdata))
        else $error("Low limit high byte not stored.");

    AST_LOW_LIMIT_LO_WRITE: assert property (
        wrAt(stiu_pkg::ADDR_LOW_LIM_LO) |=> lowLimit[7:0] == $past(regWdata))
        else $error("Low limit low byte not stored.");

    AST_HIGH_LIMIT_WRITE: assert property (
        wrAt(stiu_pkg::ADDR_HIGH_LIM_LO) |=> highLimit[7:0] == $past(regWdata))
        else $error("High limit low byte not stored.");

    AST_HIGH_LIMIT_HI_WRITE: assert property (
        wrAt(stiu_pkg::ADDR_HIGH_LIM_HI)
        |=> highLimit[15:8] == $past(regWdata))
        else $error("High limit high byte not stored.");

    AST_STATUS_READ: assert property (
        (regRead && regAddr == stiu_pkg::ADDR_IRQ_STATUS)
        |=> regRdata[stiu_pkg::STAT_W-1:0] == $past(irqStatus))
        else $error("Status read does not show the flags.");

    AST_BIO_CLEAR: assert property (
        sBioClear |=> !irqStatus[stiu_pkg::STAT_BIO_RDY] ##1
            (irqStatus[stiu_pkg::STAT_BIO_RDY] == $past(bioValid) &&
             bio_ready_irq_enable || !irqStatus[stiu_pkg::STAT_BIO_RDY]))
        else $error("Writing one did not clear the bio ready flag.");

    AST_FLAG_HOLDS: assert property (
        (irqStatus[stiu_pkg::STAT_HIGH] && !statClr[stiu_pkg::STAT_HIGH])
        |=> irqStatus[stiu_pkg::STAT_HIGH])
        else $error("High flag dropped without a clear.");

    AST_HIT_SETS_FLAG: assert property (
        (hitLow && limit_irq_enable) |=> irqStatus[stiu_pkg::STAT_LOW])
        else $error("Low hit did not set the low flag.");

    AST_HIT_SETS_HIGH: assert property (
        (hitHigh && limit_irq_enable) |=> irqStatus[stiu_pkg::STAT_HIGH])
        else $error("High hit did not set the high flag.");

    AST_PIN_FOLLOWS: assert property (
        intN == (irqStatus == stiu_pkg::STAT_RESET))
        else $error("Interrupt pin disagrees with the status flags.");
endmodule : stiu_top
`default_nettype wire

/* sim/stiu_host_model.sv */
// Host model driving the byte register port of the interrupt unit.
// Assumes the device takes strobes on the rising edge of sys_clk.
`timescale 1ns/100ps
`default_nettype none
module stiu_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] regRdata,
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata
);
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Released lines show the inverse, so stale values never pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask : rd
endmodule : stiu_host_model
`default_nettype wire

/* sim/stiu_top_tb.sv */
// Self-checking bench for the sensor threshold interrupt unit.
// Assumes the host model and the unit share sys_clk at 25 MHz.
`timescale 1ns/100ps
`default_nettype none
module stiu_top_tb;
    logic sys_clk;
    logic nrst = 1'b0;
    logic [7:0] regAddr, regWdata, regRdata, rb;
    logic regWrite, regRead, intN, sel;
    logic bioValid = 1'b0;
    logic alsValid = 1'b0;
    logic [15:0] bioData = 16'h0000;
    logic [15:0] alsData = 16'h0000;
    logic [15:0] lo, hi, v, s;
    int badCount = 0;
    int totalChecks = 0;
    int seed = 23968;
    stiu_top stiu_top_inst (.sys_clk(sys_clk), .nrst(nrst),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .bioValid(bioValid),
        .bioData(bioData), .alsValid(alsValid), .alsData(alsData),
        .intN(intN));
    stiu_host_model stiu_host_model_inst (.sys_clk(sys_clk),
        .regRdata(regRdata), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata));
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] expFlags(input logic [15:0] x);
        return {6'h00, (x < lo) && !(x > hi), x > hi};
    endfunction : expFlags
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        totalChecks++;
        if (g !== e)
        begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        stiu_host_model_inst.rd(a, rb);
        chk("register", {8'h00, e}, {8'h00, rb});
    endtask : rdChk
    // Status is read two edges late so a limit flag has landed.
    task automatic chkStat(input logic [7:0] e);
        repeat (2) @(posedge sys_clk);
        rdChk(stiu_pkg::ADDR_IRQ_STATUS, e);
        chk("intN", {15'h0000, e == 8'h00}, {15'h0000, intN});
    endtask : chkStat
    task automatic meas(input logic bio, input logic [15:0] d);
        @(posedge sys_clk);
        bioValid <= bio;
        alsValid <= !bio;
        bioData <= d;
        alsData <= d;
        @(posedge sys_clk);
        bioValid <= 1'b0;
        alsValid <= 1'b0;
        bioData <= ~d;
        alsData <= ~d;
    endtask : meas
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask : giveVerdict
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        badCount++;
        $display("[ERR] run expected done seen timeout");
        giveVerdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int a = 'h86; a <= 'h90; a++)
        begin
            rdChk(a[7:0], 8'h00);
        end
        chk("intN", 16'h0001, {15'h0000, intN});
        stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_CTRL, 8'hFF);
        rdChk(stiu_pkg::ADDR_IRQ_CTRL, stiu_pkg::CTRL_MASK);
        $display("test reset and control done");
        lo = 16'h0100 + (16'($random(seed)) & 16'h3FFF);
        hi = 16'hC000 + (16'($random(seed)) & 16'h3FFE);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_LOW_LIM_HI, lo[15:8]);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_LOW_LIM_LO, lo[7:0]);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_HIGH_LIM_HI, hi[15:8]);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_HIGH_LIM_LO, hi[7:0]);
        rdChk(stiu_pkg::ADDR_LOW_LIM_HI, lo[15:8]);
        rdChk(stiu_pkg::ADDR_LOW_LIM_LO, lo[7:0]);
        rdChk(stiu_pkg::ADDR_HIGH_LIM_HI, hi[15:8]);
        rdChk(stiu_pkg::ADDR_HIGH_LIM_LO, hi[7:0]);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_CTRL, 8'h00);
        v = 16'($random(seed));
        meas(1'b1, v);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_BIO_RES_HI, ~v[15:8]);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_BIO_RES_LO, ~v[7:0]);
        rdChk(stiu_pkg::ADDR_BIO_RES_HI, v[15:8]);
        rdChk(stiu_pkg::ADDR_BIO_RES_LO, v[7:0]);
        $display("test limits and result done");
        for (int e = 0; e < 4; e++)
        begin
            stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_CTRL,
                {4'h0, e[1:0], 2'b00});
            meas(1'b1, lo);
            meas(1'b0, hi);
            chkStat({4'h0, e[1:0], 2'b00});
            stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_STATUS, 8'h08);
            chkStat({4'h0, 1'b0, e[0], 2'b00});
            stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_STATUS, 8'h0F);
        end
        $display("test ready enables done");
        // Interleaved samples of the other source must not count.
        for (int c = 0; c < 8; c++)
        begin
            sel = c[0];
            s = (c < 4) ? (c[1] ? 16'hFFFF : hi + 16'h0001) : lo - 16'h0001;
            stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_CTRL,
                {1'b0, c[2:0], 2'b00, 1'b1, sel});
            meas(!sel, hi);
            repeat ((1 << c) - 1)
            begin
                meas(!sel, s);
                meas(sel, s);
            end
            chkStat(8'h00);
            meas(!sel, s);
            chkStat(expFlags(s));
            stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_STATUS, 8'h0F);
        end
        $display("test consecutive counts done");
        stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_CTRL, 8'h20);
        repeat (4) meas(1'b1, hi + 16'h0001);
        chkStat(8'h00);
        stiu_host_model_inst.wr(stiu_pkg::ADDR_IRQ_CTRL, 8'h22);
        meas(1'b1, lo);
        repeat (3) meas(1'b1, hi + 16'h0001);
        meas(1'b1, lo);
        repeat (3) meas(1'b1, hi + 16'h0001);
        chkStat(8'h00);
        meas(1'b1, hi + 16'h0001);
        chkStat(8'h01);
        $display("test enable and restart done");
        giveVerdict();
    end
endmodule : stiu_top_tb
`default_nettype wire
